// >>> include/sebs_pkg.sv
package sebs_pkg;

	localparam int ADDR_MAX_W = 15;
	localparam int ADDR_SMALL_W = 14;
	localparam int PAGE_W = 6;
	localparam int PAGE_BYTES = 64;
	localparam int BYTE_W = 8;
	localparam int SEL_W = 3;
	localparam int TYPE_W = 4;
	localparam int TIMER_W = 32;
	localparam int PROT_W = 3;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [PROT_W-1:0] PROT_TOP = 3'h7;

	// Program cycle time in microseconds and the clock period in picoseconds.
	localparam longint unsigned PROG_TIME_US = 64'd10000;
	localparam longint unsigned CLK_PERIOD_PS = 64'd5000;
	localparam longint unsigned PS_PER_US = 64'd1000000;
	// A longest time, so the division rounds down.
	localparam longint unsigned PROG_CYCLES_DEF = PROG_TIME_US * PS_PER_US / CLK_PERIOD_PS;

	// Device type code; the value is arbitrary.
	localparam logic [TYPE_W-1:0] DEV_TYPE_DEF = 4'h5;

	typedef enum logic [1:0] {
		B_DEV = 2'b00,
		B_AHI = 2'b01,
		B_ALO = 2'b10,
		B_DATA = 2'b11
	} sebs_byte_t;

	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_RX = 4'h1,
		S_ACK = 4'h2,
		S_TX = 4'h3,
		S_RACK = 4'h4,
		S_RNEXT = 4'h5,
		S_WAIT = 4'h6,
		S_PROG = 4'h7
	} sebs_state_t;

	typedef struct packed {
		logic scl;
		logic sda;
		logic wp;
		logic [SEL_W-1:0] sel;
	} sebs_pins_t;

	typedef struct packed {
		logic we;
		logic [PAGE_W-1:0] off;
		logic [BYTE_W-1:0] data;
	} sebs_pgwr_t;

endpackage

// >>> src/sebs_sync.sv
`timescale 1ns/1ps
module sebs_sync #(
	parameter int W = 6,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sebs_sync_t;

	sebs_sync_t r;
	sebs_sync_t next_r;

	// Only the second stage is visible outside.
	always_comb begin
		next_r.s1 = din;
		next_r.s2 = r.s1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= {INIT, INIT};
		end else begin
			r <= next_r;
		end
	end

	assign dout = r.s2;
endmodule

// >>> src/sebs_array.sv
`timescale 1ns/1ps
module sebs_array
	import sebs_pkg::*;
#(
	parameter int ADDR_W = ADDR_SMALL_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [ADDR_MAX_W-1:0] rd_addr,
	output logic [BYTE_W-1:0] rd_data,
	input wire sebs_pkg::sebs_pgwr_t pg,
	input wire logic pg_clear,
	input wire logic commit,
	input wire logic [ADDR_MAX_W-1:0] base,
	input wire logic wp,
	output logic busy
);
	typedef struct packed {
		logic run;
		logic [PAGE_W-1:0] ptr;
		logic [PAGE_BYTES-1:0] valid;
		logic [BYTE_W-1:0] rd;
	} sebs_arr_t;

	logic [BYTE_W-1:0] mem [2**ADDR_W];
	logic [BYTE_W-1:0] pbuf [PAGE_BYTES];
	sebs_arr_t r;
	sebs_arr_t next_r;
	logic [ADDR_W-1:0] wr_addr;
	logic mem_we;

	always_comb begin
		next_r = r;
		wr_addr = {base[ADDR_W-1:PAGE_W], r.ptr};
		mem_we = 1'b0;
		next_r.rd = mem[rd_addr[ADDR_W-1:0]];
		if (r.run) begin
			// Protect is sampled live per byte, not latched.
			mem_we = r.valid[r.ptr] && !(wp && wr_addr[ADDR_W-1 -: PROT_W] == PROT_TOP);
			next_r.ptr = r.ptr + 1'b1;
			if (&r.ptr) begin
				next_r.run = 1'b0;
				next_r.valid = '0;
			end
		end else if (commit) begin
			next_r.run = 1'b1;
			next_r.ptr = '0;
		end else if (pg_clear) begin
			next_r.valid = '0;
		end else if (pg.we) begin
			// A later byte at the same offset replaces the earlier one.
			next_r.valid[pg.off] = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// Storage has no reset; contents after power-up are undefined.
	always_ff @(posedge clk) begin
		if (pg.we && !r.run) begin
			pbuf[pg.off] <= pg.data;
		end
		if (mem_we) begin
			mem[wr_addr] <= pbuf[r.ptr];
		end
	end

	assign rd_data = r.rd;
	assign busy = r.run;
endmodule

// >>> src/sebs_core.sv
// Contract
// - Sample data on bus clock rise, change outgoing data on bus clock fall.
// - Data line is open drain: pull low or release.
// - Data falling with clock high is a start; every transaction begins so.
// - Data rising with clock high is a stop; after a read it idles.
// - Stop after write data launches the program cycle, then standby.
// - Each byte is followed by a ninth clock carrying the receiver's acknowledge.
// - In writes, acknowledge low after device word, both address bytes, each data byte.
// - After a read byte release; low ack sends next byte, nack plus stop idles.
// - Without low ack or stop after a read byte, stay released, send nothing.
// - Device word: type code, select bits 2,1,0, then direction bit.
// - Direction 0 starts a write, direction 1 starts a read.
// - On type and select match, acknowledge low and proceed.
// - On type or select mismatch, return to standby silently.
// - Three strapped select pins allow eight devices on one bus.
// - Byte write: device word, two address bytes, one data byte, then stop.
// - During the program cycle, ignore all clock and data activity.
// - Extra data bytes advance the six page offset bits, up to 64.
// - Page offset wraps within the page; earlier buffered data is replaced.
// - Write device word during program cycle is not acknowledged; afterwards it is.
// - Protect pin high blocks writes to the upper eighth of the array.
// - Protect pin low allows all writes; reads work regardless.
// - Program cycle lasts at most 10 ms from stop to end.
// - Address counter holds last accessed location plus one; undefined at power-up (here reset clears it to 0).
`timescale 1ns/1ps
module sebs_core
	import sebs_pkg::*;
#(
	parameter int ADDR_W = ADDR_SMALL_W,
	parameter logic [TYPE_W-1:0] DEV_TYPE = DEV_TYPE_DEF,
	parameter int unsigned PROG_CYCLES = int'(PROG_CYCLES_DEF)
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	input wire logic wp_i,
	input wire logic [sebs_pkg::SEL_W-1:0] sel_i
);
	import sebs_pkg::*;

	localparam logic [ADDR_MAX_W-1:0] AMASK = ADDR_MAX_W'((1 << ADDR_W) - 1);
	localparam logic [TIMER_W-1:0] TIMER_END = TIMER_W'(PROG_CYCLES - 1);

	typedef struct packed {
		sebs_state_t st;
		sebs_byte_t idx;
		logic [2:0] cnt;
		logic [BYTE_W-1:0] sh;
		logic [BYTE_W-1:0] tx;
		logic rw;
		logic drive;
		logic ack_live;
		logic [ADDR_MAX_W-1:0] addr;
		logic [BYTE_W-1:0] ahi;
		logic wr_pend;
		logic [TIMER_W-1:0] timer;
		logic scl_d;
		logic sda_d;
		logic commit;
		logic pg_clear;
		sebs_pgwr_t pg;
	} sebs_core_t;

	sebs_core_t r;
	sebs_core_t next_r;
	sebs_pins_t raw;
	sebs_pins_t pin;
	logic [BYTE_W-1:0] rd_data;
	logic [BYTE_W-1:0] rx_byte;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;
	logic arr_busy;

	assign raw.scl = scl_i;
	assign raw.sda = sda_i;
	assign raw.wp = wp_i;
	assign raw.sel = sel_i;

	// Every pin is asynchronous to clk, including the bus clock itself.
	// Bus lines reset to their idle high level, so release of reset fakes no clock edge.
	sebs_sync #(
		.W($bits(sebs_pins_t)),
		.INIT({1'b1, 1'b1, 1'b0, {SEL_W{1'b0}}})
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.din(raw),
		.dout(pin)
	);

	sebs_array #(
		.ADDR_W(ADDR_W)
	) u_array (
		.clk(clk),
		.rst_n(rst_n),
		.rd_addr(r.addr),
		.rd_data(rd_data),
		.pg(r.pg),
		.pg_clear(r.pg_clear),
		.commit(r.commit),
		.base(r.addr),
		.wp(pin.wp),
		.busy(arr_busy)
	);

	always_comb begin
		scl_rise = pin.scl && !r.scl_d;
		scl_fall = !pin.scl && r.scl_d;
		// Data moves only with the clock low, so these edges are unambiguous.
		start = pin.scl && r.scl_d && r.sda_d && !pin.sda;
		stop = pin.scl && r.scl_d && !r.sda_d && pin.sda;
		// Bits arrive most significant first.
		rx_byte = {r.sh[BYTE_W-2:0], pin.sda};
	end

	always_comb begin
		next_r = r;
		next_r.scl_d = pin.scl;
		next_r.sda_d = pin.sda;
		next_r.commit = 1'b0;
		next_r.pg_clear = 1'b0;
		next_r.pg.we = 1'b0;
		if (r.st == S_PROG) begin
			// Bus is deaf until the cycle ends, so polling goes unanswered.
			if (r.timer >= TIMER_END && !arr_busy) begin
				next_r.st = S_IDLE;
			end else begin
				next_r.timer = r.timer + 1'b1;
			end
		end else if (start) begin
			next_r.st = S_RX;
			next_r.idx = B_DEV;
			next_r.cnt = BIT_FIRST;
			next_r.drive = 1'b0;
			next_r.ack_live = 1'b0;
			next_r.rw = 1'b0;
			// A repeated start abandons any data not closed by a stop.
			next_r.wr_pend = 1'b0;
			next_r.pg_clear = 1'b1;
		end else if (stop) begin
			next_r.drive = 1'b0;
			if (r.wr_pend) begin
				next_r.st = S_PROG;
				next_r.timer = '0;
				next_r.commit = 1'b1;
				next_r.wr_pend = 1'b0;
			end else begin
				next_r.st = S_IDLE;
			end
		end else begin
			unique case (r.st)
				S_IDLE, S_WAIT: begin
					next_r.drive = 1'b0;
				end
				S_RX: begin
					if (scl_rise) begin
						next_r.sh = rx_byte;
						next_r.cnt = r.cnt + 1'b1;
						if (r.cnt == BIT_LAST) begin
							next_r.st = S_ACK;
							next_r.ack_live = 1'b0;
							unique case (r.idx)
								B_DEV: begin
									// Type, then select 2..0, then direction.
									if (rx_byte[BYTE_W-1 -: TYPE_W] == DEV_TYPE &&
										rx_byte[SEL_W:1] == pin.sel) begin
										next_r.rw = rx_byte[0];
									end else begin
										next_r.st = S_IDLE;
									end
								end
								B_AHI: begin
									next_r.ahi = rx_byte;
								end
								B_ALO: begin
									// Upper address bits beyond the array are dropped.
									next_r.addr = ADDR_MAX_W'({r.ahi, rx_byte}) & AMASK;
								end
								B_DATA: begin
									next_r.pg.we = 1'b1;
									next_r.pg.off = r.addr[PAGE_W-1:0];
									next_r.pg.data = rx_byte;
									next_r.wr_pend = 1'b1;
									// Only the page offset moves, so it wraps in page.
									next_r.addr[PAGE_W-1:0] = r.addr[PAGE_W-1:0] + 1'b1;
								end
							endcase
						end
					end
				end
				S_ACK: begin
					if (scl_fall) begin
						if (!r.ack_live) begin
							// Hold low through the whole ninth clock.
							next_r.drive = 1'b1;
							next_r.ack_live = 1'b1;
						end else begin
							next_r.ack_live = 1'b0;
							next_r.drive = 1'b0;
							next_r.cnt = BIT_FIRST;
							if (r.rw) begin
								// Reads ignore the protect pin.
								next_r.st = S_TX;
								next_r.tx = rd_data;
								next_r.drive = !rd_data[BYTE_W-1];
								next_r.addr = (r.addr + 1'b1) & AMASK;
							end else begin
								next_r.st = S_RX;
								if (r.idx != B_DATA) begin
									next_r.idx = sebs_byte_t'(r.idx + 1'b1);
								end
							end
						end
					end
				end
				S_TX: begin
					if (scl_fall) begin
						if (r.cnt == BIT_LAST) begin
							// Released so the master can answer.
							next_r.drive = 1'b0;
							next_r.st = S_RACK;
						end else begin
							next_r.tx = r.tx << 1;
							next_r.drive = !r.tx[BYTE_W-2];
							next_r.cnt = r.cnt + 1'b1;
						end
					end
				end
				S_RACK: begin
					if (scl_rise) begin
						// No low acknowledge: stay released until start or stop.
						next_r.st = pin.sda ? S_WAIT : S_RNEXT;
					end
				end
				S_RNEXT: begin
					if (scl_fall) begin
						next_r.st = S_TX;
						next_r.cnt = BIT_FIRST;
						next_r.tx = rd_data;
						next_r.drive = !rd_data[BYTE_W-1];
						next_r.addr = (r.addr + 1'b1) & AMASK;
					end
				end
				S_PROG: begin
					next_r.drive = 1'b0;
				end
				default: begin
					next_r.st = S_IDLE;
					next_r.drive = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.scl_d <= 1'b1;
			r.sda_d <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// Open drain: the line is only ever pulled low, never driven high.
	assign sda_o = 1'b0;
	assign sda_oe_n = !r.drive;
endmodule

// >>> tb/sebs_core_asserts.sv
`timescale 1ns/1ps
module sebs_core_asserts
	import sebs_pkg::*;
#(
	parameter int ADDR_W = ADDR_SMALL_W,
	parameter logic [TYPE_W-1:0] DEV_TYPE = DEV_TYPE_DEF,
	parameter int unsigned PROG_CYCLES = 200
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_n,
	input wire logic wp_i,
	input wire logic [sebs_pkg::SEL_W-1:0] sel_i
);
	logic s1, d1, miss, wr;
	logic [11:0] r;
	logic [7:0] sh;
	int unsigned tmr;
	wire logic hit = sh[7:1] == {DEV_TYPE, sel_i};
	// The quiet window stops 16 cycles early: the core sees the stop a few cycles late.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= 1'b1;
			d1 <= 1'b1;
			r <= 12'h000;
			sh <= 8'h00;
			miss <= 1'b0;
			wr <= 1'b0;
			tmr <= 0;
		end else begin
			s1 <= scl_i;
			d1 <= sda_i;
			if (tmr != 0)
				tmr <= tmr - 1;
			if (r == 12'h008) begin
				miss <= !hit;
				wr <= hit && !sh[0] && tmr < 17;
			end
			if (s1 && scl_i && d1 && !sda_i) begin
				r <= 12'h000;
				miss <= 1'b0;
				wr <= 1'b0;
			end else if (!s1 && scl_i) begin
				r <= r + 12'(r != 12'hFFF);
				sh <= {sh[6:0], sda_i};
			end
			if (s1 && scl_i && !d1 && sda_i && wr && r >= 12'h024 && tmr == 0)
				tmr <= PROG_CYCLES + 16;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_ack;
		##[2:6] !sda_oe_n ##1 !sda_oe_n [*4];
	endsequence
	property p_od; sda_o == 1'b0; endproperty
	a_od: assert property (p_od) else $error("pin value not low");
	property p_chg; $changed(sda_oe_n) |-> !scl_i; endproperty
	a_chg: assert property (p_chg) else $error("drive moved with clock high");
	property p_hold; $fell(sda_oe_n) |-> !sda_oe_n [*8]; endproperty
	a_hold: assert property (p_hold) else $error("low pulse too short");
	property p_rel; $fell(sda_oe_n) |-> ##[1:300] $rose(sda_oe_n); endproperty
	a_rel: assert property (p_rel) else $error("line not released");
	property p_quiet; r < 12'h008 |-> sda_oe_n; endproperty
	a_quiet: assert property (p_quiet) else $error("drive during device word");
	property p_miss; miss |-> sda_oe_n; endproperty
	a_miss: assert property (p_miss) else $error("answer to other device");
	property p_poll; tmr > 16 |-> sda_oe_n; endproperty
	a_poll: assert property (p_poll) else $error("answer while programming");
	property p_ack_dw; r == 12'h008 && $fell(scl_i) && hit && tmr == 0 |-> s_ack; endproperty
	a_ack_dw: assert property (p_ack_dw) else $error("device word not acked");
	property p_ack_wr; wr && r > 12'h008 && r % 12'h009 == 12'h008 && $fell(scl_i) |-> s_ack;
	endproperty
	a_ack_wr: assert property (p_ack_wr) else $error("write byte not acked");
endmodule
bind sebs_core sebs_core_asserts #(.ADDR_W(ADDR_W), .DEV_TYPE(DEV_TYPE),
	.PROG_CYCLES(PROG_CYCLES)) u_chk (.clk(clk), .rst_n(rst_n), .scl_i(scl_i),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .wp_i(wp_i), .sel_i(sel_i));

// >>> tb/sebs_master.sv
`timescale 1ns/1ps
module sebs_master (
	input wire logic clk,
	output logic scl,
	output logic sda_m,
	input wire logic sda
);
	initial scl = 1'b1;
	initial sda_m = 1'b1;
	task automatic t(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic bit_x(input logic b, output logic v);
		sda_m = b;
		t(8);
		scl = 1'b1;
		t(8);
		v = sda;
		t(8);
		scl = 1'b0;
		t(8);
	endtask
	task automatic start();
		sda_m = 1'b1;
		t(8);
		scl = 1'b1;
		t(8);
		sda_m = 1'b0;
		t(8);
		scl = 1'b0;
		t(8);
	endtask
	// The clock is left high after a stop and stands still until the next start.
	task automatic stop();
		sda_m = 1'b0;
		t(8);
		scl = 1'b1;
		t(8);
		sda_m = 1'b1;
		t(8);
	endtask
	task automatic xb(input logic [7:0] d, input logic ab, output logic [7:0] q,
		output logic ak);
		for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
		bit_x(ab, ak);
	endtask
endmodule

// >>> tb/sebs_core_tb.sv
`timescale 1ns/1ps
module sebs_core_tb;
	import sebs_pkg::*;
	localparam logic [2:0] SEL = 3'h5;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wp_i = 1'b0;
	logic [2:0] sel_i = SEL;
	logic scl, sda_m, sda_o, sda_oe_n, k;
	logic [7:0] q;
	wire logic sda = sda_m & (sda_oe_n | sda_o);
	int mismatches = 0;
	int checks = 0;
	int cyc = 0;
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
$display("[ERR] %s expected %h seen %h", n, e, g); end end
	always #2.5 clk = ~clk;
	sebs_core #(.PROG_CYCLES(1000)) dut (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_n(sda_oe_n), .wp_i(wp_i), .sel_i(sel_i));
	sebs_master m (.clk(clk), .scl(scl), .sda_m(sda_m), .sda(sda));
	function automatic logic [7:0] dw(input logic [2:0] s, input logic rd);
		return {DEV_TYPE_DEF, s, rd};
	endfunction
	task automatic put(input logic [7:0] d);
		m.xb(d, 1'b1, q, k);
		`CHK("write ack", 1'b0, k)
	endtask
	task automatic hdr(input logic [14:0] a);
		m.start();
		put(dw(SEL, 1'b0));
		put({1'b0, a[14:8]});
		put(a[7:0]);
	endtask
	// Polls are short compared with the program cycle, so several can see it busy; only the first is checked busy.
	task automatic poll();
		int n;
		n = 0;
		k = 1'b1;
		while (k && n < 8) begin
			m.start();
			m.xb(dw(SEL, 1'b0), 1'b1, q, k);
			m.stop();
			if (n == 0) `CHK("busy poll", 1'b1, k)
			n++;
		end
		`CHK("poll end", 1'b0, k)
	endtask
	task automatic wbyte(input logic [14:0] a, input logic [7:0] d);
		hdr(a);
		put(d);
		m.stop();
		poll();
	endtask
	task automatic rd(input logic [14:0] a, input logic [7:0] e);
		hdr(a);
		m.start();
		m.xb(dw(SEL, 1'b1), 1'b1, q, k);
		`CHK("read ack", 1'b0, k)
		m.xb(8'hFF, 1'b1, q, k);
		`CHK("read byte", e, q)
		m.stop();
	endtask
	task automatic sc_select();
		for (int s = 0; s < 8; s++) begin
			sel_i = 3'(s);
			m.start();
			m.xb(dw(3'(s), 1'b0), 1'b1, q, k);
			`CHK("select ack", 1'b0, k)
			m.start();
			m.xb(dw(3'(s) ^ 3'h2, 1'b0), 1'b1, q, k);
			`CHK("select miss", 1'b1, k)
			m.stop();
		end
		sel_i = SEL;
		m.start();
		m.xb({DEV_TYPE_DEF ^ 4'h8, SEL, 1'b0}, 1'b1, q, k);
		`CHK("type miss", 1'b1, k)
		m.stop();
	endtask
	task automatic sc_page();
		hdr(15'h013E);
		for (int i = 0; i < 66; i++) put(8'h40 + 8'(i));
		m.stop();
		poll();
		hdr(15'h0100);
		m.start();
		m.xb(dw(SEL, 1'b1), 1'b1, q, k);
		for (int o = 0; o < 64; o++) begin
			m.xb(8'hFF, o == 63, q, k);
			`CHK("page byte", 8'h42 + 8'(o), q)
		end
		m.xb(8'hFF, 1'b1, q, k);
		`CHK("after nack", 8'hFF, q)
		m.stop();
	endtask
	task automatic sc_protect();
		wbyte(15'h3900, 8'hA1);
		wp_i = 1'b1;
		wbyte(15'h7900, 8'hB2);
		wbyte(15'h0200, 8'hC3);
		rd(15'h3900, 8'hA1);
		rd(15'h0200, 8'hC3);
		wp_i = 1'b0;
		wbyte(15'h7900, 8'hD4);
		rd(15'h3900, 8'hD4);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			mismatches++;
			give_verdict();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		sc_select();
		sc_page();
		sc_protect();
		give_verdict();
	end
endmodule
